// file: cnbr_ctrl.sv
/*
 * special-cycle sequencer: nmi latch and vectoring, bus hold and grant,
 * halt exit and reset entry and recovery.
 * assumes the execution core reports machine-cycle and instruction ends
 * on i_clk, and that pins are external and pass two flip-flops here.
 */
`timescale 1ns/100ps
`default_nettype none
// ********************************************************************
// Functional notes
// ********************************************************************
// Functional notes
// - nmi sampled together with maskable request
// - nmi beats maskable; never software blocked
// - nmi acknowledge fetch discards memory byte
// - restart saves return, jumps to 0066
// - bus hold sampled at cycle end
// - release bus lines on next edge
// - enabled maskable request also exits halt
// - during reset buses float, controls inactive
// - three t cycles after reset release
// - reset clears program counter to zero
// - grant asserted once lines are released
// - halt keeps running no-op refresh cycles
// - reset clears enable, vector, refresh, mode
// - nmi taken at instruction end unless bus held
module cnbr_ctrl
   import cnbr_pkg::*;
(
   input wire logic i_clk,                    // 250 MHz clock
   input wire logic i_rst_b,                  // async reset, active low
   input wire logic i_nmi_n,                  // nmi pin, falling edge
   input wire logic i_int_n,                  // maskable request pin
   input wire logic i_bus_hold_request_n,     // bus hold request pin
   input wire logic i_cycle_last,             // last t of machine cycle
   input wire logic i_instr_end,              // last t of instruction
   input wire logic i_halt_exec,              // core executed halt
   input wire logic i_ei,                     // core sets enable flipflop
   input wire logic i_di,                     // core clears enable flipflop
   input wire logic [CNBR_AW-1:0] i_next_pc,  // core's next pc
   input wire logic [CNBR_DW-1:0] i_data_in,  // data pins inward
   input wire logic [CNBR_AW-1:0] i_core_addr,// core address
   input wire logic [CNBR_DW-1:0] i_core_data,// core write data
   input wire logic i_core_data_oe,           // core drives data
   input wire logic [3:0] i_core_strobe_n,    // mreq, io, rd, wr from core
   output logic [CNBR_AW-1:0] o_addr,         // address pins
   output logic o_addr_oe,                    // address drive enable
   output logic [CNBR_DW-1:0] o_data,         // data pins outward
   output logic o_data_oe,                    // data drive enable
   output logic [3:0] o_strobe_n,             // mreq, io_strobe, rd, wr
   output logic o_strobe_oe,                  // strobe drive enable
   output logic o_bus_grant_n,                // bus grant, active low
   output logic o_halt_n,                     // halted, active low
   output logic o_running,                    // core may execute
   output logic o_nmi_fetch,                  // dummy fetch cycle
   output logic o_int_ack,                    // maskable acknowledge
   output logic [CNBR_AW-1:0] o_program_counter, // program counter
   output logic [CNBR_AW-1:0] o_return_point, // pushed on restart
   output logic [CNBR_DW-1:0] o_opcode,       // fetched byte to core
   output logic o_interrupt_enable_flipflop,  // maskable enable
   output logic [CNBR_DW-1:0] o_vector_base,  // vector base register
   output logic [CNBR_DW-1:0] o_refresh,      // refresh register
   output logic [1:0] o_int_mode              // interrupt mode
);
   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] sync1_reg;   // first stage, read only by second
   logic [2:0] sync2_reg;   // second stage: nmi, int, hold
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
      end else begin
         sync1_reg <= {i_nmi_n, i_int_n, i_bus_hold_request_n};
         sync2_reg <= sync1_reg;
      end
   end
   wire nmi_s_n = sync2_reg[2];   // synced nmi
   wire int_s_n = sync2_reg[1];   // synced maskable request
   wire hold_s_n = sync2_reg[0];  // synced hold request

   // ****************************************************************
   // nmi edge latch
   // ****************************************************************
   logic nmi_prev_reg;   // delayed synced nmi
   logic nmi_pend_reg;   // latched edge
   cnbr_state_t state_reg;
   cnbr_state_t state_next;
   wire nmi_fall = nmi_prev_reg & ~nmi_s_n;
   wire nmi_take = state_reg == CNBR_NMI_ACK;
   // set wins over clear on the same edge
   wire nmi_pend_next = nmi_fall | (nmi_pend_reg & ~nmi_take);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         nmi_prev_reg <= 1'b1;
         nmi_pend_reg <= 1'b0;
      end else begin
         nmi_prev_reg <= nmi_s_n;
         nmi_pend_reg <= nmi_pend_next;
      end
   end

   // ****************************************************************
   // bus hold and grant
   // ****************************************************************
   logic hold_reg;   // bus released
   logic hold_next;
   // sampled at cycle end, released next edge, kept until request drops
   always_comb begin
      hold_next = hold_reg;
      if (hold_reg) begin
         hold_next = ~hold_s_n;
      end else if (i_cycle_last && !hold_s_n) begin
         hold_next = 1'b1;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hold_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   logic [1:0] rec_cnt_reg;   // recovery t counter
   logic [1:0] rec_cnt_next;
   wire point = i_instr_end & ~hold_reg;   // nmi and int sample instant
   wire int_ok = ~int_s_n & o_interrupt_enable_flipflop;
   always_comb begin
      state_next = state_reg;
      rec_cnt_next = rec_cnt_reg;
      case (state_reg)
         CNBR_RECOVER: begin
            rec_cnt_next = rec_cnt_reg + CNBR_CNT_ONE;
            if (rec_cnt_next == CNBR_RECOVER_T) begin
               state_next = CNBR_RUN;
               rec_cnt_next = CNBR_CNT_ZERO;
            end
         end
         CNBR_RUN, CNBR_HALTED: begin
            if (point && nmi_pend_reg) begin
               state_next = CNBR_NMI_ACK;
            end else if (point && int_ok) begin
               state_next = CNBR_INT_ACK;
            end else if (state_reg == CNBR_RUN && i_halt_exec) begin
               state_next = CNBR_HALTED;
            end
         end
         CNBR_NMI_ACK: begin
            if (i_cycle_last && !hold_reg) begin
               state_next = CNBR_RESTART;
            end
         end
         CNBR_RESTART: state_next = CNBR_RUN;
         CNBR_INT_ACK: begin
            if (i_cycle_last && !hold_reg) begin
               state_next = CNBR_RUN;
            end
         end
         default: state_next = CNBR_RECOVER;
      endcase
   end
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= CNBR_RECOVER;
         rec_cnt_reg <= CNBR_CNT_ZERO;
      end else begin
         state_reg <= state_next;
         rec_cnt_reg <= rec_cnt_next;
      end
   end

   // ****************************************************************
   // architectural registers
   // ****************************************************************
   wire ret_load = state_reg == CNBR_NMI_ACK && state_next == CNBR_RESTART;
   wire ie_next = (state_next == CNBR_INT_ACK) ? 1'b0 :
                  i_ei ? 1'b1 : i_di ? 1'b0 : o_interrupt_enable_flipflop;
   // pc keeps its reset value until recovery ends, so the first fetch
   // after reset still goes to the reset address
   wire [CNBR_AW-1:0] pc_next = (state_reg == CNBR_RESTART) ?
                  CNBR_NMI_VECTOR :
                  (state_reg == CNBR_RECOVER) ?
                  o_program_counter : i_next_pc;
   wire refresh_step = i_cycle_last && !hold_reg && state_reg != CNBR_RECOVER;
   // refresh counter runs in halt too, keeping memory refreshed
   wire [CNBR_DW-1:0] refresh_next = refresh_step ?
                  o_refresh + 8'h01 : o_refresh;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_program_counter <= CNBR_RESET_PC;
         o_return_point <= CNBR_RESET_PC;
         o_interrupt_enable_flipflop <= 1'b0;
         o_vector_base <= CNBR_REG_CLEAR;
         o_refresh <= CNBR_REG_CLEAR;
         o_int_mode <= CNBR_IM_RESET;
         o_opcode <= CNBR_REG_CLEAR;
      end else begin
         o_program_counter <= pc_next;
         if (ret_load) begin
            o_return_point <= o_program_counter;
         end
         o_interrupt_enable_flipflop <= ie_next;
         o_refresh <= refresh_next;
         // the nmi acknowledge byte never reaches the core
         if (state_reg != CNBR_NMI_ACK) begin
            o_opcode <= i_data_in;
         end
      end
   end

   // ****************************************************************
   // pin drivers
   // ****************************************************************
   wire quiet = hold_next || state_next == CNBR_RECOVER;
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_addr <= CNBR_RESET_PC;
         o_addr_oe <= 1'b0;
         o_data <= CNBR_REG_CLEAR;
         o_data_oe <= 1'b0;
         o_strobe_n <= 4'hF;
         o_strobe_oe <= 1'b0;
         o_bus_grant_n <= 1'b1;
         o_halt_n <= 1'b1;
         o_running <= 1'b0;
         o_nmi_fetch <= 1'b0;
         o_int_ack <= 1'b0;
      end else begin
         o_addr <= i_core_addr;
         o_addr_oe <= ~hold_next;
         o_data <= i_core_data;
         o_data_oe <= i_core_data_oe & ~quiet;
         o_strobe_n <= quiet ? 4'hF : i_core_strobe_n;
         o_strobe_oe <= ~hold_next;
         o_bus_grant_n <= ~hold_next;
         o_halt_n <= state_next != CNBR_HALTED;
         o_running <= state_next == CNBR_RUN;
         o_nmi_fetch <= state_next == CNBR_NMI_ACK;
         o_int_ack <= state_next == CNBR_INT_ACK;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   chk_grant_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !o_bus_grant_n |-> !o_addr_oe && !o_data_oe && !o_strobe_oe)
      else $error("grant while lines driven");
   chk_hold_sample: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_bus_grant_n && i_cycle_last && !hold_s_n |=> !o_bus_grant_n)
      else $error("hold not honoured next edge");
   chk_hold_keep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !o_bus_grant_n && !hold_s_n |=> !o_bus_grant_n)
      else $error("grant dropped while requested");
   chk_nmi_latch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      nmi_fall |=> nmi_pend_reg)
      else $error("nmi edge lost");
   chk_nmi_prio: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      state_reg == CNBR_RUN && point && nmi_pend_reg |=> o_nmi_fetch)
      else $error("nmi not preferred");
   chk_nmi_vector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      state_reg == CNBR_RESTART |=> o_program_counter == CNBR_NMI_VECTOR)
      else $error("nmi vector wrong");
   chk_opcode_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      state_reg == CNBR_NMI_ACK |=> $stable(o_opcode))
      else $error("ack byte taken");
   chk_recover_len: assert property (@(posedge i_clk)
      $rose(i_rst_b) |-> !o_running [*3] ##1 o_running)
      else $error("recovery length wrong");
endmodule : cnbr_ctrl
`default_nettype wire

// file: cnbr_far_side.sv
/*
 * far-side model: memory answering reads and an external bus master.
 * assumes one clock shared with the block; bench commands the master.
 */
`timescale 1ns/100ps
`default_nettype none
module cnbr_far_side (
   input wire logic i_clk,                 // shared clock
   input wire logic i_want_bus,            // bench asks master to take bus
   input wire logic [3:0] i_strobe_n,      // mreq, io, rd, wr from block
   output logic o_bus_hold_request_n,      // hold request, active low
   output logic [7:0] o_data               // memory byte toward block
);
   // ****************************************************************
   // behaviour
   // ****************************************************************
   initial o_bus_hold_request_n = 1'b1;
   initial o_data = 8'h5a;
   // master changes its request just after an edge and holds it
   always @(posedge i_clk) begin
      o_bus_hold_request_n <= #1 ~i_want_bus;
   end
   // memory answers reads with fresh bytes, otherwise a toggling pattern
   always @(posedge i_clk) begin
      if (i_strobe_n[1] == 1'b0) begin
         o_data <= #1 o_data + 8'h35;
      end else begin
         o_data <= #1 ~o_data;
      end
   end
endmodule : cnbr_far_side
`default_nettype wire

// file: cnbr_pkg.sv
/*
 * package for the special-cycle control block: timing counts, vectors,
 * reset values and the state encoding.
 * assumes a single 250 MHz clock domain.
 */
package cnbr_pkg;
   // ****************************************************************
   // widths and fixed values
   // ****************************************************************
   localparam int CNBR_AW = 16;                        // address width
   localparam int CNBR_DW = 8;                         // data width
   localparam logic [15:0] CNBR_NMI_VECTOR = 16'h0066; // nmi restart point
   localparam logic [15:0] CNBR_RESET_PC = 16'h0000;   // first fetch address
   localparam logic [7:0] CNBR_REG_CLEAR = 8'h00;      // vector base, refresh
   localparam logic [1:0] CNBR_IM_RESET = 2'h0;        // interrupt mode 0
   localparam logic [1:0] CNBR_RECOVER_T = 2'h3;       // t cycles after reset
   localparam logic [1:0] CNBR_CNT_ZERO = 2'h0;        // counter idle value
   localparam logic [1:0] CNBR_CNT_ONE = 2'h1;         // counter step

   // ****************************************************************
   // sequencer states, one-hot
   // ****************************************************************
   typedef enum logic [5:0] {
      CNBR_RECOVER = 6'b00_0001,   // post-reset t cycles
      CNBR_RUN = 6'b00_0010,       // normal processing
      CNBR_NMI_ACK = 6'b00_0100,   // dummy fetch, byte discarded
      CNBR_RESTART = 6'b00_1000,   // push return point, jump to vector
      CNBR_HALTED = 6'b01_0000,    // no-op cycles with refresh
      CNBR_INT_ACK = 6'b10_0000    // maskable acknowledge handoff
   } cnbr_state_t;
endpackage : cnbr_pkg

// file: tb_top.sv
/*
 * self-checking bench for the special-cycle sequencer.
 * assumes cnbr_pkg and cnbr_ctrl are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cnbr_pkg::*;
   logic i_clk, i_rst_b, i_nmi_n, i_int_n, hold_n, i_cycle_last;
   logic i_instr_end, i_halt_exec, i_ei, i_di, i_core_data_oe, want_bus;
   logic [15:0] i_next_pc, i_core_addr, o_addr, o_program_counter;
   logic [7:0] i_core_data, mem_data, o_data, o_opcode, o_vector_base;
   logic [7:0] o_refresh;
   logic [3:0] i_core_strobe_n, o_strobe_n;
   logic o_addr_oe, o_data_oe, o_strobe_oe, o_bus_grant_n, o_halt_n;
   logic o_running, o_nmi_fetch, o_int_ack, o_interrupt_enable_flipflop;
   logic [1:0] o_int_mode;
   logic [15:0] o_return_point, ret_exp;   // pushed pc and its expectation
   logic [7:0] op_exp;                     // byte the core should keep
   logic [5:0] exp_q[$];              // expected status notes
   logic [5:0] prev_snap;
   wire [5:0] snap = {o_nmi_fetch, o_int_ack, ~o_bus_grant_n, o_addr_oe,
                      o_strobe_oe, o_halt_n};
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic watch_on = 1'b0;
   integer seed = 32'h9a7e_d95e;

   cnbr_ctrl i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_nmi_n(i_nmi_n),
      .i_int_n(i_int_n), .i_bus_hold_request_n(hold_n),
      .i_cycle_last(i_cycle_last), .i_instr_end(i_instr_end),
      .i_halt_exec(i_halt_exec), .i_ei(i_ei), .i_di(i_di),
      .i_next_pc(i_next_pc), .i_data_in(mem_data), .i_core_addr(i_core_addr),
      .i_core_data(i_core_data), .i_core_data_oe(i_core_data_oe),
      .i_core_strobe_n(i_core_strobe_n), .o_addr(o_addr),
      .o_addr_oe(o_addr_oe), .o_data(o_data), .o_data_oe(o_data_oe),
      .o_strobe_n(o_strobe_n), .o_strobe_oe(o_strobe_oe),
      .o_bus_grant_n(o_bus_grant_n), .o_halt_n(o_halt_n),
      .o_running(o_running), .o_nmi_fetch(o_nmi_fetch),
      .o_int_ack(o_int_ack), .o_program_counter(o_program_counter),
      .o_return_point(o_return_point), .o_opcode(o_opcode),
      .o_interrupt_enable_flipflop(o_interrupt_enable_flipflop),
      .o_vector_base(o_vector_base), .o_refresh(o_refresh),
      .o_int_mode(o_int_mode));
   cnbr_far_side i_far (.i_clk(i_clk), .i_want_bus(want_bus),
      .i_strobe_n(o_strobe_n), .o_bus_hold_request_n(hold_n),
      .o_data(mem_data));

   // ****************************************************************
   // clock, timeout, checking
   // ****************************************************************
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // comparison shared by every check
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict
   // hang guard
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // watcher: each status change takes the oldest note
   always @(negedge i_clk) begin
      if (watch_on && snap !== prev_snap) begin
         if (exp_q.size() == 0) begin
            check({10'h0, snap}, 16'hffff);
         end else begin
            check({10'h0, snap}, {10'h0, exp_q.pop_front()});
         end
      end
      prev_snap <= snap;
   end
   // random core traffic, changed at the falling edge
   always @(negedge i_clk) begin
      i_next_pc <= $random(seed);
      i_core_addr <= $random(seed);
      i_core_data <= $random(seed);
      i_core_strobe_n <= $random(seed);
      i_core_data_oe <= $random(seed);
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask : cyc
   initial begin
      {i_rst_b, i_nmi_n, i_int_n} = 3'b011;
      {i_cycle_last, i_instr_end, i_halt_exec, i_ei, i_di} = 5'b0;
      want_bus = 1'b0;
      cyc(4);
      check({o_addr_oe, o_data_oe, o_strobe_oe, o_strobe_n}, 16'h000f);
      check({o_bus_grant_n, o_interrupt_enable_flipflop, o_int_mode}, 16'h8);
      check({o_vector_base, o_refresh}, 16'h0000);
      check(o_program_counter, CNBR_RESET_PC);
      watch_on = 1'b1;
      exp_q.push_back(6'b000111);
      i_rst_b = 1'b1;
      cyc(2);
      check(o_running, 1'b0);
      cyc(1);
      check(o_running, 1'b1);
      check(o_program_counter, CNBR_RESET_PC);
      cyc(1);
      // core traffic passes to the pins while the bus is owned
      check(o_addr, i_core_addr);
      check({o_data, o_strobe_n, 3'h0, o_data_oe},
            {i_core_data, i_core_strobe_n, 3'h0, i_core_data_oe});
      i_di = 1'b1;
      cyc(1);
      {i_di, i_ei} = 2'b01;
      cyc(1);
      i_ei = 1'b0;
      cyc(1);
      check(o_interrupt_enable_flipflop, 1'b1);
      // short nmi pulse while the maskable request is also low
      {i_nmi_n, i_int_n} = 2'b00;
      cyc(3);
      i_nmi_n = 1'b1;
      cyc(3);
      exp_q.push_back(6'b100111);
      op_exp = mem_data;
      {i_instr_end, i_cycle_last} = 2'b11;
      cyc(1);
      ret_exp = i_next_pc;
      {i_instr_end, i_int_n} = 2'b01;
      exp_q.push_back(6'b000111);
      cyc(1);
      check(o_opcode, op_exp);
      i_cycle_last = 1'b0;
      cyc(1);
      check(o_program_counter, CNBR_NMI_VECTOR);
      check(o_return_point, ret_exp);
      // bus hold with random core data traffic
      want_bus = 1'b1;
      exp_q.push_back(6'b001001);
      cyc(4);
      i_cycle_last = 1'b1;
      cyc(1);
      i_cycle_last = 1'b0;
      cyc(1);
      check({o_data_oe, o_strobe_n}, 16'h000f);
      repeat (6) begin
         i_cycle_last = ~i_cycle_last;
         cyc(1);
      end
      check(o_bus_grant_n, 1'b0);
      exp_q.push_back(6'b000111);
      want_bus = 1'b0;
      cyc(6);
      // halt, then exit on an enabled maskable request
      exp_q.push_back(6'b000110);
      i_halt_exec = 1'b1;
      cyc(1);
      i_halt_exec = 1'b0;
      cyc(3);
      check(o_halt_n, 1'b0);
      i_int_n = 1'b0;
      cyc(4);
      exp_q.push_back(6'b010111);
      {i_instr_end, i_cycle_last} = 2'b11;
      cyc(1);
      {i_instr_end, i_cycle_last, i_int_n} = 3'b001;
      cyc(2);
      // four owned cycle ends so far, the last one while halted
      check(o_refresh, 8'h04);
      watch_on = 1'b0;
      check(exp_q.size(), 16'h0000);
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
